//--- scratch_mem.sv
// input scratchpad, written on the link clock, read on the bus clock
`timescale 1ns/1ps
module scratch_mem
  import wire_cmd_pkg::*;
(
  input wire logic wclk_i,
  input wire logic we_i,
  input wire logic [MEM_AW-1:0] wa_i,
  input wire logic [7:0] wd_i,
  input wire logic rclk_i,
  input wire logic re_i,
  input wire logic [MEM_AW-1:0] ra_i,
  output logic [7:0] rd_o
);
  logic [7:0] mem_q [2**MEM_AW];

  always_ff @(posedge wclk_i) begin
    if (we_i) begin
      mem_q[wa_i] <= wd_i;
    end
  end

  always_ff @(posedge rclk_i) begin
    if (re_i) begin
      rd_o <= mem_q[ra_i];
    end
  end
endmodule : scratch_mem

//--- sync2.sv
// two-flop synchroniser for a bundle of levels
`timescale 1ns/1ps
module sync2 #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] s1_q;

  always_ff @(posedge clk_i) begin
    s1_q <= d_i;
    q_o <= s1_q;
  end
endmodule : sync2

//--- wire_cmd_exec.sv
// triplet and block receive executor with bus registers and wire slot engine
`timescale 1ns/1ps
// Behaviour
// - refuse command while wire busy; discard it
// - triplet ends within three slots plus startup
// - wire activity starts within 1.1us
// - triplet acceptance points read pointer at status
// - busy held through three slots, then cleared
// - first result at sample one, others slot two
// - triplet uses speed, pullup and slot timings
// - parameter bit 7 picks branch on 00
// - code e1h reads 1 to 63 bytes
// - block ends within bytes times eight slots
// - block acceptance points read pointer at status
// - busy held eight slots per byte
// - block uses speed, pullup, recovery, one-low, resistance
// - size bits 5:0, zero means one byte
// - triplet code 78h, repeated by host
// - write slot chosen from both read bits
module wire_cmd_exec
  import wire_cmd_pkg::*;
#(
  parameter int SLOT_STD_CYC = SLOT_STD_DEF
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [8:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic wire_clk_i,
  input wire logic wire_i,
  output logic wire_o,
  output logic wire_oe_o,
  output logic [PUR_W-1:0] pullup_res_o
);
  typedef enum logic [1:0] {LS_IDLE, LS_SLOT} link_st_e;

  // bus domain state
  logic ack_q, pend_q;
  logic [31:0] dat_q, rd_d;
  logic busy_q, ref_q, op_q, start_tog_q;
  logic [7:0] param_q, ptr_q;
  logic [1:0] cfg_q;
  logic [PUR_W-1:0] pur_q;
  logic [CW-1:0] tim_q [TIM_N];
  logic [2:0] res_q;
  logic [1:0] ev_s, ev_prev_q;
  logic [7:0] mem_rd;
  logic [7:0] a;
  logic wr_en, cmd_wr, code_ok, ref_clr;
  logic done_ev, upd_ev;

  // link domain state
  logic [2:0] ls;
  logic lrst, st_prev_q, start_ev, ws;
  link_st_e st_q;
  logic [CW-1:0] cnt_q;
  logic [2:0] bit_q;
  logic [BS_W-1:0] byte_q, last_q;
  logic lop_q, lv_q, lspd_q, lapu_q;
  logic [CW-1:0] lw0l_q, lw1l_q, lrec_q;
  logic [7:0] sh_q;
  logic [2:0] lres_q;
  logic upd_tog_q, done_tog_q;
  logic mwe_q;
  logic [MEM_AW-1:0] mwa_q;
  logic [7:0] mwd_q;
  logic wo_q, woe_q;
  logic [CW-1:0] slot_len, msr;
  logic [CW:0] lo, need, endc, apu_from;
  logic rd_slot, wbit;

  assign a = {wb_adr_i[7:2], 2'b00};
  assign wr_en = ack_q & wb_cyc_i & wb_stb_i & wb_we_i;
  assign cmd_wr = wr_en & ~wb_adr_i[SCR_BIT] & (a == ADR_CMD) & (&wb_sel_i[1:0]);
  assign code_ok = (wb_dat_i[7:0] == CMD_TRIPLET) | (wb_dat_i[7:0] == CMD_BLOCK);
  assign ref_clr = wr_en & ~wb_adr_i[SCR_BIT] & (a == ADR_STAT) & wb_sel_i[0]
                   & wb_dat_i[STAT_REF];
  assign done_ev = ev_s[1] ^ ev_prev_q[1];
  assign upd_ev = ev_s[0] ^ ev_prev_q[0];
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // wishbone handshake: request seen, one wait cycle, then ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      pend_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else if (ce_i) begin
      ack_q <= pend_q;
      pend_q <= wb_cyc_i & wb_stb_i & ~pend_q & ~ack_q;
      if (pend_q & ~wb_we_i) begin
        dat_q <= rd_d;
      end
    end
  end

  // read data selection
  always_comb begin
    rd_d = 32'h0000_0000;
    if (wb_adr_i[SCR_BIT]) begin
      rd_d[7:0] = mem_rd;
    end else begin
      case (a)
        ADR_STAT: begin
          rd_d[STAT_BUSY] = busy_q;
          rd_d[STAT_REF] = ref_q;
          rd_d[STAT_RES +: 3] = res_q;
        end
        ADR_CFG: rd_d[1:0] = cfg_q;
        ADR_PTR: rd_d[7:0] = ptr_q;
        ADR_PUR: rd_d[PUR_W-1:0] = pur_q;
        default: begin
          for (int i = 0; i < TIM_N; i++) begin
            if (a == ADR_TIM + TIM_STEP * 8'(i)) begin
              rd_d[CW-1:0] = tim_q[i];
            end
          end
        end
      endcase
    end
  end

  // configuration, held while a command runs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_q <= 2'b00;
      pur_q <= '0;
    end else if (ce_i & wr_en & ~wb_adr_i[SCR_BIT] & ~busy_q & wb_sel_i[0]) begin
      if (a == ADR_CFG) begin
        cfg_q <= wb_dat_i[1:0];
      end
      if (a == ADR_PUR) begin
        pur_q <= wb_dat_i[PUR_W-1:0];
      end
    end
  end

  // timing registers, one per slot time
  generate
    for (genvar i = 0; i < TIM_N; i++) begin : g_tim
      localparam logic [CW-1:0] RST_V = (i == TIM_W0L) ? W0L_RST :
                                        (i == TIM_W1L) ? W1L_RST : REC_RST;
      logic hit;
      assign hit = ce_i & wr_en & ~wb_adr_i[SCR_BIT] & ~busy_q
                   & (a == ADR_TIM + TIM_STEP * 8'(i));
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          tim_q[i] <= RST_V;
        end else if (hit) begin
          if (wb_sel_i[0]) begin
            tim_q[i][7:0] <= wb_dat_i[7:0];
          end
          if (wb_sel_i[1]) begin
            tim_q[i][CW-1:8] <= wb_dat_i[CW-1:8];
          end
        end
      end
    end
  endgenerate

  // command acceptance and busy flag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_q <= 1'b0;
      op_q <= 1'b0;
      param_q <= 8'h00;
      start_tog_q <= 1'b0;
    end else if (ce_i) begin
      if (cmd_wr & ~busy_q & code_ok) begin
        busy_q <= 1'b1;
        op_q <= (wb_dat_i[7:0] == CMD_BLOCK);
        param_q <= wb_dat_i[15:8];
        start_tog_q <= ~start_tog_q;
      end else if (done_ev) begin
        busy_q <= 1'b0;
      end
    end
  end

  // refused flag, set wins over clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ref_q <= 1'b0;
    end else if (ce_i) begin
      ref_q <= (cmd_wr & (busy_q | ~code_ok)) | (ref_q & ~ref_clr);
    end
  end

  // read pointer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ptr_q <= PTR_RESET;
    end else if (ce_i) begin
      if (cmd_wr & ~busy_q & code_ok) begin
        ptr_q <= PTR_STATUS;
      end else if (wr_en & ~wb_adr_i[SCR_BIT] & (a == ADR_PTR) & wb_sel_i[0]) begin
        ptr_q <= wb_dat_i[7:0];
      end
    end
  end

  // events back from the link domain
  sync2 #(.W(2)) u_bsync (
    .clk_i(clk_i),
    .d_i({done_tog_q, upd_tog_q}),
    .q_o(ev_s)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ev_prev_q <= 2'b00;
      res_q <= 3'b000;
    end else if (ce_i) begin
      ev_prev_q <= ev_s;
      if (upd_ev) begin
        res_q <= lres_q;
      end
    end
  end

  scratch_mem u_mem (
    .wclk_i(wire_clk_i),
    .we_i(mwe_q),
    .wa_i(mwa_q),
    .wd_i(mwd_q),
    .rclk_i(clk_i),
    .re_i(ce_i),
    .ra_i(wb_adr_i[MEM_AW+1:2]),
    .rd_o(mem_rd)
  );

  assign pullup_res_o = pur_q;
  // link domain: reset, start toggle and wire level
  sync2 #(.W(3)) u_lsync (
    .clk_i(wire_clk_i),
    .d_i({rst_i, start_tog_q, wire_i}),
    .q_o(ls)
  );
  assign lrst = ls[2];
  assign ws = ls[0];
  assign start_ev = ls[1] ^ st_prev_q;

  // per slot timing from the captured configuration
  assign slot_len = lspd_q ? CW'(SLOT_OD_CYC) : CW'(SLOT_STD_CYC);
  assign msr = lspd_q ? CW'(MSR_OD_CYC) : CW'(MSR_STD_CYC);
  assign rd_slot = lop_q | (bit_q != 3'(TRI_LAST));
  assign wbit = rd_slot | lres_q[RES_DIR];
  assign lo = {1'b0, wbit ? lw1l_q : lw0l_q};
  assign need = lo + {1'b0, lrec_q};
  assign endc = ((need > {1'b0, slot_len}) ? need : {1'b0, slot_len}) - 1'b1;
  assign apu_from = endc + 1'b1 - {1'b0, lrec_q};
  // slot sequencer
  always_ff @(posedge wire_clk_i) begin
    if (lrst) begin
      st_q <= LS_IDLE;
      st_prev_q <= 1'b0;
      cnt_q <= '0;
      bit_q <= 3'd0;
      byte_q <= '0;
      last_q <= '0;
      lop_q <= 1'b0;
      lv_q <= 1'b0;
      lspd_q <= 1'b0;
      lapu_q <= 1'b0;
      lw0l_q <= W0L_RST;
      lw1l_q <= W1L_RST;
      lrec_q <= REC_RST;
      done_tog_q <= 1'b0;
    end else begin
      st_prev_q <= ls[1];
      case (st_q)
        LS_IDLE: begin
          if (start_ev) begin
            st_q <= LS_SLOT;
            cnt_q <= '0;
            bit_q <= 3'd0;
            byte_q <= '0;
            lop_q <= op_q;
            lv_q <= param_q[PARAM_V];
            last_q <= (param_q[BS_W-1:0] == '0) ? '0 : param_q[BS_W-1:0] - 1'b1;
            lspd_q <= cfg_q[CFG_SPD];
            lapu_q <= cfg_q[CFG_APU];
            lw0l_q <= tim_q[TIM_W0L];
            lw1l_q <= tim_q[TIM_W1L];
            lrec_q <= tim_q[TIM_REC];
          end
        end
        LS_SLOT: begin
          cnt_q <= cnt_q + 1'b1;
          if ({1'b0, cnt_q} == endc) begin
            cnt_q <= '0;
            if (~lop_q & (bit_q == 3'(TRI_LAST))) begin
              st_q <= LS_IDLE;
              done_tog_q <= ~done_tog_q;
            end else if (lop_q & (bit_q == 3'(BIT_LAST))) begin
              bit_q <= 3'd0;
              byte_q <= byte_q + 1'b1;
              if (byte_q == last_q) begin
                st_q <= LS_IDLE;
                done_tog_q <= ~done_tog_q;
              end
            end else begin
              bit_q <= bit_q + 1'b1;
            end
          end
        end
        default: st_q <= LS_IDLE;
      endcase
    end
  end

  // sampling: triplet results and block bytes
  always_ff @(posedge wire_clk_i) begin
    if (lrst) begin
      lres_q <= 3'b000;
      upd_tog_q <= 1'b0;
      sh_q <= 8'h00;
      mwe_q <= 1'b0;
      mwa_q <= '0;
      mwd_q <= 8'h00;
    end else begin
      mwe_q <= 1'b0;
      if ((st_q == LS_SLOT) & rd_slot & (cnt_q == msr)) begin
        if (lop_q) begin
          sh_q <= {ws, sh_q[7:1]};
          if (bit_q == 3'(BIT_LAST)) begin
            mwe_q <= 1'b1;
            mwa_q <= byte_q;
            mwd_q <= {ws, sh_q[7:1]};
          end
        end else if (bit_q == 3'd0) begin
          lres_q[RES_SBR] <= ws;
          upd_tog_q <= ~upd_tog_q;
        end else begin
          lres_q[RES_TSB] <= ws;
          lres_q[RES_DIR] <= lres_q[RES_SBR] | (~ws & lv_q);
          upd_tog_q <= ~upd_tog_q;
        end
      end
    end
  end

  // wire drive: low phase, then optional active pullup in recovery
  always_ff @(posedge wire_clk_i) begin
    if (lrst) begin
      wo_q <= 1'b0;
      woe_q <= 1'b0;
    end else begin
      wo_q <= (st_q == LS_SLOT) & lapu_q & ({1'b0, cnt_q} >= apu_from);
      woe_q <= (st_q == LS_SLOT)
               & (({1'b0, cnt_q} < lo) | (lapu_q & ({1'b0, cnt_q} >= apu_from)));
    end
  end

  assign wire_o = wo_q;
  assign wire_oe_o = woe_q;
endmodule : wire_cmd_exec

//--- wire_cmd_exec_bench.sv
// self-checking bench for the wire command executor
`timescale 1ns/1ps
module wire_cmd_exec_bench;
  import wire_cmd_pkg::*;
  localparam int SB = SLOT_OD_CYC * LINK_PS / CLK_PS;
  localparam int STD_SIM = 3000;
  localparam int SB_STD = STD_SIM * LINK_PS / CLK_PS;
  logic clk_i, rst_i, ce_i, wire_clk_i, wire_o, wire_oe_o, pull, lvl;
  logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [8:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [PUR_W-1:0] pullup_res_o;
  int fails = 0;
  int checks = 0;
  int cyc_n = 0;
  int t0;
  int slot_clk = SB;
  assign lvl = (wire_oe_o ? wire_o : 1'b1) & !pull;
  wire_cmd_exec #(.SLOT_STD_CYC(STD_SIM)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wire_clk_i(wire_clk_i), .wire_i(lvl),
    .wire_o(wire_o), .wire_oe_o(wire_oe_o), .pullup_res_o(pullup_res_o)
  );
  wire_slave_model i_slave (.line_i(lvl), .pull_o(pull));
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  initial begin
    wire_clk_i = 1'b0;
    #1.7;
    forever #3 wire_clk_i = ~wire_clk_i;
  end
  always @(posedge clk_i) cyc_n <= cyc_n + 1;
  task automatic tally_and_finish;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wb(input logic we, input logic [8:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, adr, dat};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    if (n >= 50) begin
      fails++;
      tally_and_finish();
    end
  endtask : wb
  task automatic rchk(input logic [8:0] adr, input logic [31:0] exp);
    wb(1'b0, adr, 32'h0);
    chk(rd, exp);
  endtask : rchk
  task automatic wait_idle(input int lo, input int hi);
    int n;
    n = 0;
    do begin
      wb(1'b0, 9'(ADR_STAT), 32'h0);
      n++;
    end while (rd[STAT_BUSY] !== 1'b0 && n < 4000);
    chk(32'(cyc_n - t0 >= lo && cyc_n - t0 <= hi), 32'h1);
    if (n >= 4000) begin
      fails++;
      tally_and_finish();
    end
  endtask : wait_idle
  task automatic setup_regs;
    rchk(9'(ADR_PTR), 32'(PTR_RESET));
    rchk(9'h010, 32'(W0L_RST));
    rchk(9'h014, 32'(W1L_RST));
    rchk(9'h018, 32'(REC_RST));
    rchk(9'h020, 32'h0);
    wb(1'b1, 9'h008, 32'h1);
    wb(1'b1, 9'h010, 32'd60);
    wb(1'b1, 9'h014, 32'd10);
    wb(1'b1, 9'h018, 32'd8);
    wb(1'b1, 9'h01c, 32'h2);
    rchk(9'h008, 32'h1);
    rchk(9'h01c, 32'h2);
  endtask : setup_regs
  task automatic triplet(input logic r1, input logic r2, input logic v, input logic rf);
    logic d;
    d = r1 | (!r2 & v);
    i_slave.load({125'h0, 1'b1, r2, r1}, 3);
    wb(1'b1, 9'(ADR_PTR), 32'h0);
    wb(1'b1, 9'(ADR_CMD), {16'h0, v, 7'h55, CMD_TRIPLET});
    t0 = cyc_n;
    rchk(9'(ADR_PTR), 32'(PTR_STATUS));
    repeat (slot_clk) @(posedge clk_i);
    wb(1'b0, 9'(ADR_STAT), 32'h0);
    chk({rd[STAT_BUSY], rd[STAT_RES+RES_SBR]}, {1'b1, r1});
    if (rf) begin
      wb(1'b1, 9'(ADR_CMD), {16'h0, 8'h01, CMD_BLOCK});
      wb(1'b0, 9'(ADR_STAT), 32'h0);
      chk(rd[STAT_REF], 1'b1);
      wb(1'b1, 9'(ADR_STAT), 32'h2);
      wb(1'b0, 9'(ADR_STAT), 32'h0);
      chk(rd[STAT_REF], 1'b0);
    end
    wait_idle(3 * slot_clk - 20, 3 * slot_clk + 80);
    wb(1'b0, 9'(ADR_STAT), 32'h0);
    chk(rd[7:5], {d, r2, r1});
    chk(i_slave.last_q, d);
  endtask : triplet
  task automatic block(input logic [7:0] prm, input logic [15:0] data, input int n);
    i_slave.load({112'h0, data}, 8 * n);
    wb(1'b1, 9'(ADR_PTR), 32'h0);
    wb(1'b1, 9'(ADR_CMD), {16'h0, prm, CMD_BLOCK});
    t0 = cyc_n;
    rchk(9'(ADR_PTR), 32'(PTR_STATUS));
    wait_idle(8 * n * SB - 20, 8 * n * SB + 80);
    rchk(9'h100, {24'h0, data[7:0]});
    rchk(9'h104, {24'h0, data[15:8]});
    chk(i_slave.zero_q, 1'b0);
  endtask : block
  initial begin
    {rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i} = 5'b11000;
    wb_adr_i = 9'h000;
    wb_sel_i = 4'hf;
    wb_dat_i = 32'h0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    setup_regs();
    triplet(1'b0, 1'b1, 1'b1, 1'b1);
    triplet(1'b1, 1'b0, 1'b0, 1'b0);
    triplet(1'b1, 1'b1, 1'b0, 1'b0);
    triplet(1'b0, 1'b0, 1'b1, 1'b0);
    wb(1'b1, 9'h008, 32'h3);
    triplet(1'b0, 1'b0, 1'b0, 1'b0);
    wb(1'b1, 9'h008, 32'h0);
    slot_clk = SB_STD;
    i_slave.hold_ns = 16000;
    triplet(1'b1, 1'b0, 1'b0, 1'b0);
    slot_clk = SB;
    i_slave.hold_ns = 4000;
    wb(1'b1, 9'h008, 32'h1);
    repeat (1100) @(posedge clk_i);
    block(8'hc2, 16'h3ca5, 2);
    block(8'h40, 16'h3c5a, 1);
    tally_and_finish();
  end
endmodule : wire_cmd_exec_bench

//--- wire_cmd_exec_props.sv
// port checker for the wire command executor
`timescale 1ns/1ps
module wire_cmd_exec_props
  import wire_cmd_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [8:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire logic wire_clk_i,
  input wire logic wire_o,
  input wire logic wire_oe_o,
  input wire logic [PUR_W-1:0] pullup_res_o
);
  logic apu_q;
  logic [PUR_W-1:0] pur_q;
  logic [CW-1:0] w0l_q, w1l_q, rec_q, lo_q, hi_q;
  logic [9:0] idle_q;
  logic wr, lo, hi, go;
  assign wr = wb_ack_o && wb_we_i;
  assign lo = wire_oe_o && !wire_o;
  assign hi = wire_oe_o && wire_o;
  assign go = wr && wb_adr_i == 9'h000 && idle_q == 10'h3ff &&
    (wb_dat_i[7:0] == CMD_TRIPLET || wb_dat_i[7:0] == CMD_BLOCK);
  // shadow of configuration written over the bus
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      apu_q <= 1'b0;
      pur_q <= '0;
      w0l_q <= W0L_RST;
      w1l_q <= W1L_RST;
      rec_q <= REC_RST;
    end else if (wr) begin
      case (wb_adr_i)
        9'h008: apu_q <= wb_dat_i[CFG_APU];
        9'h010: w0l_q <= wb_dat_i[CW-1:0];
        9'h014: w1l_q <= wb_dat_i[CW-1:0];
        9'h018: rec_q <= wb_dat_i[CW-1:0];
        9'h01c: pur_q <= wb_dat_i[PUR_W-1:0];
        default: ;
      endcase
    end
  end
  // wire quiet time, saturating
  always_ff @(posedge clk_i) begin
    if (rst_i || wire_oe_o) begin
      idle_q <= '0;
    end else if (idle_q != 10'h3ff) begin
      idle_q <= idle_q + 10'h001;
    end
  end
  // drive pulse lengths in link cycles
  always_ff @(posedge wire_clk_i) begin
    lo_q <= lo ? lo_q + 1'b1 : '0;
    hi_q <= hi ? hi_q + 1'b1 : '0;
  end
  property p_ack_pulse;
    @(posedge clk_i) disable iff (rst_i) wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack longer than one cycle");
  property p_ack_lat;
    @(posedge clk_i) disable iff (rst_i) $rose(wb_stb_i) |-> ##[1:3] wb_ack_o;
  endproperty
  a_ack_lat: assert property (p_ack_lat)
    else $error("no ack for request");
  property p_start;
    @(posedge clk_i) disable iff (rst_i) go |-> ##[1:55] wire_oe_o;
  endproperty
  a_start: assert property (p_start)
    else $error("wire activity late");
  property p_passive;
    @(posedge wire_clk_i) disable iff (rst_i) hi |-> apu_q;
  endproperty
  a_passive: assert property (p_passive)
    else $error("drove high without active pullup");
  property p_apu_len;
    @(posedge wire_clk_i) disable iff (rst_i) $fell(hi) |-> hi_q <= rec_q + 1'b1;
  endproperty
  a_apu_len: assert property (p_apu_len)
    else $error("active pullup too long");
  property p_low_len;
    @(posedge wire_clk_i) disable iff (rst_i) $fell(lo) |->
      (lo_q >= w1l_q && lo_q <= w1l_q + 1'b1) || (lo_q >= w0l_q && lo_q <= w0l_q + 1'b1);
  endproperty
  a_low_len: assert property (p_low_len)
    else $error("low time matches no setting");
  property p_recover;
    @(posedge wire_clk_i) disable iff (rst_i) $fell(lo) |-> !lo [*8];
  endproperty
  a_recover: assert property (p_recover)
    else $error("recovery too short");
  property p_pur;
    @(posedge clk_i) disable iff (rst_i)
      (wr && wb_adr_i == 9'h01c) |-> ##2 pullup_res_o == pur_q;
  endproperty
  a_pur: assert property (p_pur)
    else $error("pullup code not applied");
endmodule : wire_cmd_exec_props

bind wire_cmd_exec wire_cmd_exec_props i_props (
  .clk_i(clk_i), .rst_i(rst_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .wire_clk_i(wire_clk_i),
  .wire_o(wire_o), .wire_oe_o(wire_oe_o), .pullup_res_o(pullup_res_o)
);

//--- wire_cmd_pkg.sv
// shared constants for the wire command executor
package wire_cmd_pkg;
  // clocks
  localparam int CLK_PS = 20000;
  localparam int LINK_PS = 6000;
  // command codes and read pointer codes
  localparam logic [7:0] CMD_TRIPLET = 8'h78;
  localparam logic [7:0] CMD_BLOCK = 8'he1;
  localparam logic [7:0] PTR_STATUS = 8'hf0;
  localparam logic [7:0] PTR_RESET = 8'h00;
  // register byte offsets; scratchpad when address bit SCR_BIT is set
  localparam logic [7:0] ADR_CMD = 8'h00;
  localparam logic [7:0] ADR_STAT = 8'h04;
  localparam logic [7:0] ADR_CFG = 8'h08;
  localparam logic [7:0] ADR_PTR = 8'h0c;
  localparam logic [7:0] ADR_TIM = 8'h10;
  localparam logic [7:0] TIM_STEP = 8'h04;
  localparam logic [7:0] ADR_PUR = 8'h1c;
  localparam int SCR_BIT = 8;
  // field positions
  localparam int STAT_BUSY = 0;
  localparam int STAT_REF = 1;
  localparam int STAT_RES = 5;
  localparam int RES_SBR = 0;
  localparam int RES_TSB = 1;
  localparam int RES_DIR = 2;
  localparam int CFG_SPD = 0;
  localparam int CFG_APU = 1;
  localparam int PARAM_V = 7;
  localparam int BS_W = 6;
  localparam int PUR_W = 2;
  // timing register index
  localparam int TIM_N = 3;
  localparam int TIM_W0L = 0;
  localparam int TIM_W1L = 1;
  localparam int TIM_REC = 2;
  localparam int CW = 16;
  localparam int MEM_AW = 6;
  localparam int BIT_LAST = 7;
  localparam int TRI_LAST = 2;
  // slot times in ns, converted to link clock cycles
  localparam int SLOT_STD_NS = 70000;
  localparam int SLOT_OD_NS = 10000;
  localparam int MSR_STD_NS = 15000;
  localparam int MSR_OD_NS = 2000;
  localparam int W0L_NS = 20000;
  localparam int W1L_NS = 6000;
  localparam int REC_NS = 5000;
  localparam int SLOT_STD_DEF = (SLOT_STD_NS * 1000 + LINK_PS - 1) / LINK_PS;
  localparam int SLOT_OD_CYC = (SLOT_OD_NS * 1000 + LINK_PS - 1) / LINK_PS;
  localparam int MSR_STD_CYC = (MSR_STD_NS * 1000) / LINK_PS;
  localparam int MSR_OD_CYC = (MSR_OD_NS * 1000) / LINK_PS;
  localparam logic [CW-1:0] W0L_RST = CW'((W0L_NS * 1000 + LINK_PS - 1) / LINK_PS);
  localparam logic [CW-1:0] W1L_RST = CW'((W1L_NS * 1000 + LINK_PS - 1) / LINK_PS);
  localparam logic [CW-1:0] REC_RST = CW'((REC_NS * 1000 + LINK_PS - 1) / LINK_PS);
endpackage : wire_cmd_pkg

//--- wire_slave_model.sv
// behavioural slave: answers slots from a bit list, logs written bits
`timescale 1ns/1ps
module wire_slave_model (
  input wire logic line_i,
  output logic pull_o
);
  logic [127:0] bits;
  int n = 0;
  int idx = 0;
  logic mine = 1'b0;
  logic last_q = 1'b1;
  logic zero_q = 1'b0;
  realtime t_fall = 0;
  realtime hold_ns = 4000;
  task automatic load(input logic [127:0] b, input int cnt);
    bits = b;
    n = cnt;
    idx = 0;
    zero_q = 1'b0;
  endtask : load
  initial pull_o = 1'b0;
  // a zero bit is held low past the sample instant
  always @(negedge line_i) begin
    t_fall = $realtime;
    mine = idx < n && !bits[idx];
    idx = idx + 1;
    if (mine) begin
      pull_o = 1'b1;
      #hold_ns pull_o = 1'b0;
    end
  end
  // a short master-only low is a write-one
  always @(posedge line_i) begin
    if (!mine) begin
      last_q = ($realtime - t_fall) < 200.0;
      zero_q = zero_q | !last_q;
    end
  end
endmodule : wire_slave_model
